// File: pkg/wic_params.svh
`ifndef WIC_PARAMS_SVH
`define WIC_PARAMS_SVH

// ----------------------------------------------------------------
// bus geometry and register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define WIC_AW          12
`define WIC_IDX_EDGE    8'hC8
`define WIC_IDX_WEN     8'hC9
`define WIC_IDX_PND     8'hCA
`define WIC_IDX_CTRL    8'hF0
`define WIC_IDX_STAT    8'hF1

// ----------------------------------------------------------------
// interrupt control register fields
// ----------------------------------------------------------------
`define WIC_CB_GIE      0
`define WIC_CB_ENI      1
`define WIC_CB_TIMER_IRQ_ENABLE     2
`define WIC_CB_EXT_IRQ_EDGE     3
`define WIC_CB_EXT_IRQ_PENDING     4
`define WIC_CB_TIMER_IRQ_PENDING     5

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define WIC_SB_HALT     0
`define WIC_SB_START    1
`define WIC_SB_BUSY     2
`define WIC_SB_BLOCK    3

// ----------------------------------------------------------------
// reset values, counts and fixed codes
// ----------------------------------------------------------------
`define WIC_RST_BYTE    8'h00
`define WIC_PRESC_LOAD  8'hFF
`define WIC_TC_LAST     4'h9
`define WIC_START_LAST  12'h09FF
`define WIC_VECTOR      16'h00FF
`define WIC_SEQ_LAST    3'h7
`define WIC_SP_STEP     8'h02
`define WIC_ROM_BLANK   8'h00
`define WIC_RAM_BLANK   8'hFF

`endif

// File: pkg/wic_pkg.sv
package wic_pkg;

    // ------------------------------------------------------------
    // modes and sequences
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WIC_RUN   = 2'b00,
        WIC_HALT  = 2'b01,
        WIC_START = 2'b10
    } wic_pwr_t;

    typedef enum logic [1:0] {
        WIC_IDLE = 2'b00,
        WIC_ACK  = 2'b01
    } wic_seq_t;

    typedef enum logic [1:0] {
        WIC_RET_PLAIN = 2'b00,
        WIC_RET_SKIP  = 2'b01,
        WIC_RET_IRQ   = 2'b10
    } wic_ret_t;

    // ------------------------------------------------------------
    // whole block state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  edge_sel;
        logic [7:0]  wake_en;
        logic [7:0]  wake_pnd;
        logic [7:0]  port_s1;
        logic [7:0]  port_s2;
        logic [7:0]  port_prev;
        logic        ext_s1;
        logic        ext_s2;
        logic        ext_prev;
        logic        global_irq_enable;
        logic        ext_irq_enable;
        logic        timer_irq_enable;
        logic        ext_irq_edge;
        logic        ext_irq_pending;
        logic        timer_irq_pending;
        wic_pwr_t    pwr;
        logic [7:0]  presc;
        logic [3:0]  tc_cnt;
        wic_seq_t    seq;
        logic [2:0]  seq_cnt;
        logic [7:0]  sp_base;
        logic [15:0] pc_save;
        logic        stack_we;
        logic [7:0]  stack_addr;
        logic [7:0]  stack_data;
        logic        pc_load;
        logic [15:0] pc_val;
        logic        sp_load;
        logic [7:0]  sp_val;
        logic        skip;
        logic [7:0]  fetch_data;
        logic [7:0]  ram_data;
        logic [31:0] prdata;
    } wic_state_t;

    localparam wic_state_t WIC_ST_RST = '0;

endpackage : wic_pkg

// File: hw/wic_top.sv
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "wic_params.svh"

// How it works
// - edge select one: falling, zero: rising
// - selected pin edge sets its pending bit
// - pending bits clear only by software write
// - halt refused while enabled pending wakeup exists
// - crystal wakeup: oscillator, prescaler FF, then clocks
// - prescaler ticks every tenth oscillator cycle
// - external, timer and opcode-zero interrupt sources
// - maskable needs global and source enable
// - hardware acknowledge clears global enable
// - external edge bit: zero rising, one falling
// - source pending flags sticky until software clears
// - setting global enable in handler allows nesting
// - software interrupt leaves global enable alone
// - push pc, sp minus two, vector 00FF, seven cycles
// - returns pop pc, sp plus two; return_enable_irq enables
// - take decided on enables before same-cycle clear
// - undefined program fetch returns 00
// - undefined data read returns FF
// - reset clears edge select and enable
module wic_top import wic_pkg::*; (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // apb slave
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [`WIC_AW-1:0]  paddr_i,
    input  wire logic [31:0]         pwdata_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    // external pins
    input  wire logic [7:0]          port_l_i,
    input  wire logic                ext_irq_pin_i,
    // power control
    input  wire logic                crystal_i,
    input  wire logic                halt_req_i,
    output logic                     halted_o,
    output logic                     osc_en_o,
    output logic                     chip_clk_en_o,
    // interrupt requests from core
    input  wire logic                instr_boundary_i,
    input  wire logic                timer_event_i,
    input  wire logic                swi_i,
    input  wire logic [15:0]         pc_i,
    input  wire logic [7:0]          sp_i,
    output logic                     irq_busy_o,
    // returns
    input  wire logic                ret_i,
    input  wire logic [1:0]          ret_kind_i,
    input  wire logic [15:0]         ret_pc_i,
    // stack and program counter updates
    output logic                     stack_we_o,
    output logic      [7:0]          stack_addr_o,
    output logic      [7:0]          stack_data_o,
    output logic                     pc_load_o,
    output logic      [15:0]         pc_o,
    output logic                     sp_load_o,
    output logic      [7:0]          sp_o,
    output logic                     skip_o,
    // memory guards
    input  wire logic                rom_defined_i,
    input  wire logic [7:0]          rom_data_i,
    output logic      [7:0]          fetch_data_o,
    input  wire logic                ram_defined_i,
    input  wire logic [7:0]          ram_data_i,
    output logic      [7:0]          ram_data_o
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [`WIC_AW-1:0] a,
                                     input logic [7:0]         idx);
        reg_hit = (a == {2'b00, idx, 2'b00});
    endfunction : reg_hit

    wic_state_t st;
    wic_state_t nx;
    logic [7:0] wake_edge;
    logic       ext_edge;
    logic       wake_block;
    logic       hw_req;
    logic       take;
    logic       wr_en;
    logic       rd_setup;
    logic       hit;
    logic       tc_tick;

    assign wr_en    = psel_i && penable_i && pwrite_i;
    assign rd_setup = psel_i && !penable_i && !pwrite_i;
    assign hit      = reg_hit(paddr_i, `WIC_IDX_EDGE) || reg_hit(paddr_i, `WIC_IDX_WEN)
                   || reg_hit(paddr_i, `WIC_IDX_PND)  || reg_hit(paddr_i, `WIC_IDX_CTRL)
                   || reg_hit(paddr_i, `WIC_IDX_STAT);

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    // per-pin edge polarity
    assign wake_edge = (st.edge_sel & st.port_prev & ~st.port_s2)
                     | (~st.edge_sel & ~st.port_prev & st.port_s2);
    assign ext_edge  = st.ext_irq_edge ? (st.ext_prev && !st.ext_s2)
                               : (!st.ext_prev && st.ext_s2);
    // enable gates both wakeup and halt blocking
    assign wake_block = |(st.wake_en & st.wake_pnd);
    assign hw_req  = st.global_irq_enable && ((st.ext_irq_enable && st.ext_irq_pending) || (st.timer_irq_enable && st.timer_irq_pending));
    // decided on registered enables, a clear this cycle is late
    assign take    = (st.seq == WIC_IDLE) && (st.pwr == WIC_RUN) && instr_boundary_i
                  && !ret_i && (swi_i || hw_req);
    assign tc_tick = (st.tc_cnt == `WIC_TC_LAST);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nx           = st;
        nx.stack_we  = 1'b0;
        nx.pc_load   = 1'b0;
        nx.sp_load   = 1'b0;
        nx.skip      = 1'b0;
        nx.port_s1   = port_l_i;
        nx.port_s2   = st.port_s1;
        nx.port_prev = st.port_s2;
        nx.ext_s1    = ext_irq_pin_i;
        nx.ext_s2    = st.ext_s1;
        nx.ext_prev  = st.ext_s2;

        if (wr_en && reg_hit(paddr_i, `WIC_IDX_EDGE)) begin
            nx.edge_sel = pwdata_i[7:0];
        end
        if (wr_en && reg_hit(paddr_i, `WIC_IDX_WEN)) begin
            nx.wake_en = pwdata_i[7:0];
        end
        if (wr_en && reg_hit(paddr_i, `WIC_IDX_PND)) begin
            nx.wake_pnd = pwdata_i[7:0];
        end
        // latch edges, set wins over clear
        nx.wake_pnd = nx.wake_pnd | wake_edge;

        // software may raise global enable anytime except the cycle a hardware acknowledge is taken
        if (wr_en && reg_hit(paddr_i, `WIC_IDX_CTRL)) begin
            nx.global_irq_enable  = pwdata_i[`WIC_CB_GIE];
            nx.ext_irq_enable  = pwdata_i[`WIC_CB_ENI];
            nx.timer_irq_enable = pwdata_i[`WIC_CB_TIMER_IRQ_ENABLE];
            nx.ext_irq_edge = pwdata_i[`WIC_CB_EXT_IRQ_EDGE];
            nx.ext_irq_pending = pwdata_i[`WIC_CB_EXT_IRQ_PENDING];
            nx.timer_irq_pending = pwdata_i[`WIC_CB_TIMER_IRQ_PENDING];
        end
        nx.ext_irq_pending = nx.ext_irq_pending || ext_edge;
        nx.timer_irq_pending = nx.timer_irq_pending || timer_event_i;

        // returns pop pc and release two stack bytes
        if (ret_i && st.seq == WIC_IDLE) begin
            nx.pc_load = 1'b1;
            nx.pc_val  = ret_pc_i;
            nx.sp_load = 1'b1;
            nx.sp_val  = sp_i + `WIC_SP_STEP;
            nx.skip    = (ret_kind_i == WIC_RET_SKIP);
            if (ret_kind_i == WIC_RET_IRQ) begin
                nx.global_irq_enable = 1'b1;
            end
        end

        // three sources, opcode zero beats maskable
        if (take) begin
            nx.seq     = WIC_ACK;
            nx.seq_cnt = 3'h1;
            nx.pc_save = pc_i;
            nx.sp_base = sp_i;
            if (!swi_i) begin
                nx.global_irq_enable = 1'b0;
            end
        end

        if (st.seq == WIC_ACK) begin
            case (st.seq_cnt)
                3'h1: begin
                    nx.stack_we   = 1'b1;
                    nx.stack_addr = st.sp_base;
                    nx.stack_data = st.pc_save[7:0];
                end
                3'h2: begin
                    nx.stack_we   = 1'b1;
                    nx.stack_addr = st.sp_base - 8'h01;
                    nx.stack_data = st.pc_save[15:8];
                end
                default: begin
                end
            endcase
            if (st.seq_cnt == `WIC_SEQ_LAST) begin
                nx.seq     = WIC_IDLE;
                nx.seq_cnt = 3'h0;
                nx.pc_load = 1'b1;
                nx.pc_val  = `WIC_VECTOR;
                nx.sp_load = 1'b1;
                nx.sp_val  = st.sp_base - `WIC_SP_STEP;
            end else begin
                nx.seq_cnt = st.seq_cnt + 3'h1;
            end
        end

        // power sequencing
        case (st.pwr)
            WIC_RUN: begin
                // halt request ignored while a wakeup is owed
                if (halt_req_i && !wake_block) begin
                    nx.pwr = WIC_HALT;
                end
            end
            WIC_HALT: begin
                // wake as soon as enabled and pending
                if (wake_block) begin
                    nx.pwr    = crystal_i ? WIC_START : WIC_RUN;
                    nx.presc  = `WIC_PRESC_LOAD;
                    nx.tc_cnt = 4'h0;
                end
            end
            WIC_START: begin
                // clocks stay gated until prescaler expires
                nx.tc_cnt = tc_tick ? 4'h0 : st.tc_cnt + 4'h1;
                if (tc_tick) begin
                    if (st.presc == 8'h00) begin
                        nx.pwr = WIC_RUN;
                    end else begin
                        nx.presc = st.presc - 8'h01;
                    end
                end
            end
            default: begin
                nx.pwr = WIC_RUN;
            end
        endcase

        // read data registered in the setup phase
        if (rd_setup) begin
            nx.prdata = 32'h0000_0000;
            if (reg_hit(paddr_i, `WIC_IDX_EDGE)) begin
                nx.prdata[7:0] = st.edge_sel;
            end
            if (reg_hit(paddr_i, `WIC_IDX_WEN)) begin
                nx.prdata[7:0] = st.wake_en;
            end
            if (reg_hit(paddr_i, `WIC_IDX_PND)) begin
                nx.prdata[7:0] = st.wake_pnd;
            end
            if (reg_hit(paddr_i, `WIC_IDX_CTRL)) begin
                nx.prdata[`WIC_CB_GIE]  = st.global_irq_enable;
                nx.prdata[`WIC_CB_ENI]  = st.ext_irq_enable;
                nx.prdata[`WIC_CB_TIMER_IRQ_ENABLE] = st.timer_irq_enable;
                nx.prdata[`WIC_CB_EXT_IRQ_EDGE] = st.ext_irq_edge;
                nx.prdata[`WIC_CB_EXT_IRQ_PENDING] = st.ext_irq_pending;
                nx.prdata[`WIC_CB_TIMER_IRQ_PENDING] = st.timer_irq_pending;
            end
            if (reg_hit(paddr_i, `WIC_IDX_STAT)) begin
                nx.prdata[`WIC_SB_HALT]  = (st.pwr == WIC_HALT);
                nx.prdata[`WIC_SB_START] = (st.pwr == WIC_START);
                nx.prdata[`WIC_SB_BUSY]  = (st.seq == WIC_ACK);
                nx.prdata[`WIC_SB_BLOCK] = wake_block;
            end
        end

        // blank program space traps as opcode zero
        nx.fetch_data = rom_defined_i ? rom_data_i : `WIC_ROM_BLANK;
        // blank data space reads all ones
        nx.ram_data   = ram_defined_i ? ram_data_i : `WIC_RAM_BLANK;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // reset clears edge and enable; pending forced to a known zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= WIC_ST_RST;
        end else begin
            st <= nx;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata_o      = st.prdata;
    assign pready_o      = 1'b1;
    assign pslverr_o     = psel_i && penable_i && !hit;
    assign halted_o      = (st.pwr == WIC_HALT);
    assign osc_en_o      = (st.pwr != WIC_HALT);
    assign chip_clk_en_o = (st.pwr == WIC_RUN);
    assign irq_busy_o    = (st.seq == WIC_ACK);
    assign stack_we_o    = st.stack_we;
    assign stack_addr_o  = st.stack_addr;
    assign stack_data_o  = st.stack_data;
    assign pc_load_o     = st.pc_load;
    assign pc_o          = st.pc_val;
    assign sp_load_o     = st.sp_load;
    assign sp_o          = st.sp_val;
    assign skip_o        = st.skip;
    assign fetch_data_o  = st.fetch_data;
    assign ram_data_o    = st.ram_data;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [11:0] start_cyc;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            start_cyc <= 12'h000;
        end else if (st.pwr == WIC_START) begin
            start_cyc <= start_cyc + 12'h001;
        end else begin
            start_cyc <= 12'h000;
        end
    end

    a_pnd_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        (|wake_edge) |=> ((st.wake_pnd & $past(wake_edge)) == $past(wake_edge)))
        else $error("wakeup edge not latched");

    a_pnd_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_en && reg_hit(paddr_i, `WIC_IDX_PND))
        |=> (($past(st.wake_pnd) & ~st.wake_pnd) == 8'h00))
        else $error("pending bit cleared by hardware");

    a_halt_refused: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.pwr == WIC_RUN && halt_req_i && wake_block) |=> (st.pwr == WIC_RUN))
        else $error("halt entered with wakeup pending");

    a_start_length: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.pwr == WIC_START && nx.pwr == WIC_RUN) |-> (start_cyc == `WIC_START_LAST))
        else $error("start-up delay length wrong");

    a_clock_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.pwr == WIC_HALT && wake_block && crystal_i)
        |=> (!chip_clk_en_o && osc_en_o) [*8])
        else $error("clocks routed before start-up expiry");

    a_ack_seven: assert property (@(posedge clk_i) disable iff (rst_i)
        take |=> irq_busy_o [*7] ##1 (!irq_busy_o && pc_load_o && pc_o == `WIC_VECTOR))
        else $error("acknowledge sequence length or vector wrong");

    a_sp_push: assert property (@(posedge clk_i) disable iff (rst_i)
        take |-> ##8 (sp_load_o && sp_o == $past(sp_i, 8) - `WIC_SP_STEP))
        else $error("stack pointer not lowered by two");

    a_gie_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && !swi_i) |=> !st.global_irq_enable)
        else $error("global enable kept on acknowledge");

    a_swi_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && swi_i && !wr_en) |=> (st.global_irq_enable == $past(st.global_irq_enable)))
        else $error("software trap changed global enable");

    a_mask_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.seq == WIC_IDLE && !swi_i
         && !(st.global_irq_enable && ((st.ext_irq_enable && st.ext_irq_pending) || (st.timer_irq_enable && st.timer_irq_pending))))
        |=> !irq_busy_o)
        else $error("masked interrupt taken");

    a_return_enable_irq_sets: assert property (@(posedge clk_i) disable iff (rst_i)
        (ret_i && st.seq == WIC_IDLE && ret_kind_i == WIC_RET_IRQ)
        |=> (st.global_irq_enable && sp_load_o && sp_o == $past(sp_i) + `WIC_SP_STEP))
        else $error("interrupt return mishandled");

    a_rom_blank: assert property (@(posedge clk_i) disable iff (rst_i)
        !rom_defined_i |=> (fetch_data_o == `WIC_ROM_BLANK))
        else $error("blank program fetch not zero");

    a_ram_blank: assert property (@(posedge clk_i) disable iff (rst_i)
        !ram_defined_i |=> (ram_data_o == `WIC_RAM_BLANK))
        else $error("blank data read not all ones");

endmodule : wic_top

// File: sim/wic_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// core side: pc, sp and stack ram seen by the interrupt block
// ----------------------------------------------------------------
module wic_core_model import wic_pkg::*; (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // updates from the block
    input  wire logic        stack_we_i,
    input  wire logic [7:0]  stack_addr_i,
    input  wire logic [7:0]  stack_data_i,
    input  wire logic        pc_load_i,
    input  wire logic [15:0] pc_i,
    input  wire logic        sp_load_i,
    input  wire logic [7:0]  sp_i,
    // core state
    output logic      [15:0] pc_o,
    output logic      [7:0]  sp_o,
    output logic      [15:0] ret_pc_o
);
    logic [7:0] mem [256];
    assign ret_pc_o = {mem[sp_o + 8'h01], mem[sp_o + 8'h02]};
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc_o <= 16'h0123;
            sp_o <= 8'h6F;
        end else begin
            if (stack_we_i) mem[stack_addr_i] <= stack_data_i;
            if (pc_load_i) pc_o <= pc_i;
            if (sp_load_i) sp_o <= sp_i;
        end
    end
endmodule : wic_core_model

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic        crystal_i = 0, halt_req_i = 0, timer_event_i = 0, swi_i = 0, ret_i = 0;
    logic        instr_boundary_i = 1;
    logic        ext_irq_pin_i = 1, rom_defined_i = 0, ram_defined_i = 0, last_err = 0;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, w;
    logic [7:0]  port_l_i = 0, rom_data_i = 0, ram_data_i = 0, e, sp0;
    logic [1:0]  ret_kind_i = 0;
    logic [15:0] pc0;
    wire  [31:0] prdata_o;
    wire         pready_o, pslverr_o, halted_o, osc_en_o, chip_clk_en_o, irq_busy_o;
    wire         stack_we_o, pc_load_o, sp_load_o, skip_o;
    wire  [7:0]  stack_addr_o, stack_data_o, sp_o, fetch_data_o, ram_data_o, msp;
    wire  [15:0] pc_o, mpc, mret;
    int          errors = 0, checked = 0, n;
    logic [31:0] exp_q[$];

    wic_top uut (.*, .pc_i(mpc), .sp_i(msp), .ret_pc_i(mret));
    wic_core_model core (.clk_i(clk_i), .rst_i(rst_i), .stack_we_i(stack_we_o),
        .stack_addr_i(stack_addr_o), .stack_data_i(stack_data_o), .pc_load_i(pc_load_o),
        .pc_i(pc_o), .sp_load_i(sp_load_o), .sp_i(sp_o), .pc_o(mpc), .sp_o(msp),
        .ret_pc_o(mret));

    always #10 clk_i = ~clk_i;

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, x, s);
        end
    endtask : chk

    task summarize;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize

    // ----------------------------------------------------------------
    // bus and core drivers
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        last_err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic halt;
        halt_req_i <= 1'b1;
        @(posedge clk_i);
        halt_req_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : halt

    // waits out the acknowledge; swi dropped early so it is not taken twice
    task automatic run_irq;
        n = 0;
        while (irq_busy_o !== 1'b1 && n < 20) begin @(posedge clk_i); n++; end
        swi_i <= 1'b0;
        n = 0;
        while (irq_busy_o === 1'b1 && n < 20) begin @(posedge clk_i); n++; end
        chk("busy_cycles", n, 7);
        @(posedge clk_i);
    endtask : run_irq

    task automatic ret(input logic [1:0] k, input logic [31:0] x);
        exp_q.push_back(x);
        ret_kind_i <= k;
        ret_i      <= 1'b1;
        @(posedge clk_i);
        ret_i <= 1'b0;
        @(posedge clk_i);
    endtask : ret

    task automatic tpulse;
        timer_event_i <= 1'b1;
        @(posedge clk_i);
        timer_event_i <= 1'b0;
    endtask : tpulse

    // scoreboard: oldest note against each read or pc load
    always @(posedge clk_i) begin
        if (psel_i && penable_i && pready_o && !pwrite_i)
            chk("prdata", prdata_o, exp_q.size() ? exp_q.pop_front() : 'x);
        if (pc_load_o === 1'b1)
            chk("pc_sp", {7'h0, skip_o, pc_o, sp_o}, exp_q.size() ? exp_q.pop_front() : 'x);
    end

    initial begin
        #(20 * 20_000);
        errors++;
        summarize;
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        w = $urandom(32'h0b11);
        w = $urandom;
        e = w[7:0];
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(12'h320, 32'h0);
        rd(12'h324, 32'h0);
        rd(12'h000, 32'h0);
        chk("slverr", 32'(last_err), 32'h1);
        $display("done registers");
        apb(1'b1, 12'h320, w);
        rd(12'h320, {24'h0, e});
        port_l_i <= ~e;
        repeat (6) @(posedge clk_i);
        apb(1'b1, 12'h328, 32'h0);
        port_l_i <= e;
        repeat (6) @(posedge clk_i);
        rd(12'h328, 32'h00);
        port_l_i <= ~e;
        repeat (6) @(posedge clk_i);
        rd(12'h328, 32'hFF);
        repeat (20) @(posedge clk_i);
        rd(12'h328, 32'hFF);
        $display("done wake edges");
        apb(1'b1, 12'h324, 32'h01);
        halt;
        chk("halt_block", 32'(halted_o), 32'h0);
        rd(12'h3C4, 32'h08);
        apb(1'b1, 12'h324, 32'h00);
        apb(1'b1, 12'h328, 32'h00);
        apb(1'b1, 12'h324, 32'h01);
        halt;
        chk("halted", {halted_o, osc_en_o}, 2'b10);
        port_l_i <= port_l_i ^ 8'h01;
        repeat (6) @(posedge clk_i);
        chk("wrong_edge", 32'(halted_o), 32'h1);
        port_l_i <= port_l_i ^ 8'h01;
        repeat (6) @(posedge clk_i);
        chk("wake", {halted_o, chip_clk_en_o}, 2'b01);
        crystal_i <= 1'b1;
        apb(1'b1, 12'h328, 32'h00);
        halt;
        port_l_i <= port_l_i ^ 8'h01;
        repeat (6) @(posedge clk_i);
        port_l_i <= port_l_i ^ 8'h01;
        n = 0;
        while (halted_o === 1'b1 && n < 20) begin @(posedge clk_i); n++; end
        chk("start", {halted_o, osc_en_o, chip_clk_en_o}, 3'b010);
        n = 0;
        while (chip_clk_en_o !== 1'b1 && n < 3000) begin @(posedge clk_i); n++; end
        chk("start_len", n, 2560);
        crystal_i <= 1'b0;
        $display("done halt and wakeup");
        apb(1'b1, 12'h3C0, 32'h04);
        tpulse;
        repeat (4) @(posedge clk_i);
        chk("masked", 32'(irq_busy_o), 32'h0);
        rd(12'h3C0, 32'h24);
        apb(1'b1, 12'h3C0, 32'h05);
        pc0 = mpc;
        sp0 = msp;
        exp_q.push_back({8'h0, 16'h00FF, sp0 - 8'h02});
        tpulse;
        run_irq;
        chk("stack", {core.mem[sp0 - 8'h01], core.mem[sp0]}, pc0);
        rd(12'h3C0, 32'h24);
        apb(1'b1, 12'h3C0, 32'h04);
        ret(2'b10, {8'h0, pc0, sp0});
        rd(12'h3C0, 32'h05);
        exp_q.push_back({8'h0, 16'h00FF, sp0 - 8'h02});
        instr_boundary_i <= 1'b0;
        swi_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("off_boundary", 32'(irq_busy_o), 32'h0);
        instr_boundary_i <= 1'b1;
        run_irq;
        rd(12'h3C0, 32'h05);
        ret(2'b01, {7'h0, 1'b1, pc0, sp0});
        apb(1'b1, 12'h3C0, 32'h0B);
        exp_q.push_back({8'h0, 16'h00FF, sp0 - 8'h02});
        ext_irq_pin_i <= 1'b0;
        run_irq;
        rd(12'h3C0, 32'h1A);
        ret(2'b00, {8'h0, pc0, sp0});
        rd(12'h3C0, 32'h1A);
        $display("done interrupts");
        for (int i = 0; i < 4; i++) begin
            w = $urandom;
            rom_defined_i <= i[0];
            ram_defined_i <= i[1];
            rom_data_i    <= w[7:0];
            ram_data_i    <= w[15:8];
            repeat (2) @(posedge clk_i);
            chk("fetch", 32'(fetch_data_o), i[0] ? {24'h0, w[7:0]} : 32'h00);
            chk("ram", 32'(ram_data_o), i[1] ? {24'h0, w[15:8]} : 32'hFF);
        end
        $display("done memory guards");
        summarize;
    end
endmodule : testbench
